// File: hw/dcc_pkg.sv
// Purpose: constants for the dual comparator control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   register offsets are byte addresses
package dcc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG     = 8'h00;
    localparam logic [7:0] OFF_AUX_CONFIG = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] OFF_COMP_IN    = 8'h10;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_B_OUT   = 7;
    localparam int BIT_A_OUT   = 6;
    localparam int BIT_B_INV   = 5;
    localparam int BIT_A_INV   = 4;
    localparam int BIT_IN_SW   = 3;
    localparam int BIT_GSS     = 1;
    localparam int BIT_SYNC    = 0;
    // ------------------------------------------------------------
    // reset values and mode codes
    // ------------------------------------------------------------
    localparam logic [5:0] RST_CONFIG_RW = 6'h00;
    localparam logic [1:0] RST_AUX       = 2'h2;
    localparam logic [2:0] MODE_RESET    = 3'h0;
    localparam logic [2:0] MODE_MUX_A    = 3'h1;
    localparam logic [2:0] MODE_MUX_AB   = 3'h2;
    localparam logic [2:0] MODE_OFF      = 3'h7;
endpackage

// File: hw/dcc_gate_if.sv
// Purpose: carries comparator b output and gate controls to the gate unit
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface dcc_gate_if;
    logic comp_b_out;
    logic gate_pin;
    logic gss;
    logic sync_en;
    logic tclk;
    logic gate;
    modport ctrl (output comp_b_out, gate_pin, gss, sync_en, tclk, input gate);
    modport unit (input comp_b_out, gate_pin, gss, sync_en, tclk, output gate);
endinterface

// File: hw/dcc_gate.sv
// Purpose: timer gate source selection and optional synchronisation
// Assumes: timer clock source is sampled as a level on SYS_CLK
// Notes:   latches comparator b on every falling timer clock edge, used when sync enabled
`timescale 1ns/1ps
module dcc_gate
(
    input  wire logic      clk,
    input  wire logic      arst_n,
    dcc_gate_if.unit       gif
);
    typedef struct packed
    {
        logic tclk_d;
        logic b_latched;
    } dcc_gate_state_t;

    dcc_gate_state_t st_reg;
    dcc_gate_state_t st_next;

    always_comb
    begin
        st_next        = st_reg;
        st_next.tclk_d = gif.tclk;
        // falling edge latch avoids racing the rising-edge increment
        if (st_reg.tclk_d && !gif.tclk)
        begin
            st_next.b_latched = gif.comp_b_out;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign gif.gate = gif.gss ? gif.gate_pin
                    : (gif.sync_en ? st_reg.b_latched : gif.comp_b_out);
endmodule

// File: hw/dcc_top.sv
// Purpose: register and control logic around two analog comparators
// Assumes: comparator raw results and timer clock arrive synchronous to SYS_CLK
// Notes:   list below names each rule the logic carries
// Function
// - reset returns both configuration registers
// - mode field resets to 000
// - output bits reflect comparison, inversion applied
// - inversion bits invert comparator outputs
// - gate select clear: comparator b gates timer
// - input switch steers inverting input, modes 001/010
// - mismatch sets flag until access or revert
// - sync latches b on falling timer clock
// - gate select 0 comparator b, 1 pin
`timescale 1ns/1ps
module dcc_top
(
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        COMP_A_RAW,
    input  wire logic        COMP_B_RAW,
    input  wire logic        TIMER_CLK_SRC,
    input  wire logic        GATE_PIN,
    output logic             TIMER_GATE,
    output logic [2:0]       COMP_MODE,
    output logic             COMP_ENABLE,
    output logic             INPUT_SWITCH,
    output logic             COMP_A_OUT,
    output logic             COMP_B_OUT,
    output logic             IRQ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic       b_inv;
        logic       a_inv;
        logic       in_sw;
        logic [2:0] mode;
        logic       gss;
        logic       sync_en;
        logic [1:0] snap;
        logic [1:0] out_q;
        logic       irq_stat;
        logic       irq_mask;
        logic [31:0] rdata;
    } dcc_state_t;

    dcc_state_t st_reg;
    dcc_state_t st_next;

    logic       setup;
    logic       access;
    logic       mapped;
    logic [1:0] outs;
    logic       mismatch;
    logic       cfg_touch;

    dcc_gate_if gif ();

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == dcc_pkg::OFF_CONFIG) || (a == dcc_pkg::OFF_AUX_CONFIG)
                 || (a == dcc_pkg::OFF_IRQ_STATUS) || (a == dcc_pkg::OFF_IRQ_MASK)
                 || (a == dcc_pkg::OFF_COMP_IN);
    endfunction

    assign setup     = PSEL && !PENABLE;
    assign access    = PSEL && PENABLE;
    assign mapped    = is_mapped(PADDR);
    // comparators are off in modes 000 and 111, so outputs read zero then
    assign COMP_ENABLE = (st_reg.mode != dcc_pkg::MODE_RESET)
                      && (st_reg.mode != dcc_pkg::MODE_OFF);
    assign outs      = COMP_ENABLE ? {COMP_B_RAW ^ st_reg.b_inv,
                                      COMP_A_RAW ^ st_reg.a_inv} : 2'h0;
    assign cfg_touch = setup && (PADDR == dcc_pkg::OFF_CONFIG);
    assign mismatch  = (st_reg.out_q != st_reg.snap);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next       = st_reg;
        st_next.out_q = outs;
        // read or write of config refreshes the snapshot
        if (cfg_touch)
        begin
            st_next.snap = outs;
        end
        if (setup && !PWRITE)
        begin
            unique case (PADDR)
                dcc_pkg::OFF_CONFIG:
                    st_next.rdata = {24'h0, outs, st_reg.b_inv, st_reg.a_inv,
                                     st_reg.in_sw, st_reg.mode};
                dcc_pkg::OFF_AUX_CONFIG:
                    st_next.rdata = {30'h0, st_reg.gss, st_reg.sync_en};
                dcc_pkg::OFF_IRQ_STATUS:
                    st_next.rdata = {31'h0, st_reg.irq_stat};
                dcc_pkg::OFF_IRQ_MASK:
                    st_next.rdata = {31'h0, st_reg.irq_mask};
                dcc_pkg::OFF_COMP_IN:
                    st_next.rdata = {30'h0, COMP_B_RAW, COMP_A_RAW};
                default:
                    st_next.rdata = 32'h0;
            endcase
        end
        if (access && PWRITE)
        begin
            unique case (PADDR)
                dcc_pkg::OFF_CONFIG:
                begin
                    // output bits are read only and are not stored
                    st_next.b_inv = PWDATA[dcc_pkg::BIT_B_INV];
                    st_next.a_inv = PWDATA[dcc_pkg::BIT_A_INV];
                    st_next.in_sw = PWDATA[dcc_pkg::BIT_IN_SW];
                    st_next.mode  = PWDATA[2:0];
                end
                dcc_pkg::OFF_AUX_CONFIG:
                begin
                    st_next.gss     = PWDATA[dcc_pkg::BIT_GSS];
                    st_next.sync_en = PWDATA[dcc_pkg::BIT_SYNC];
                end
                dcc_pkg::OFF_IRQ_STATUS:
                begin
                    if (PWDATA[0])
                    begin
                        st_next.irq_stat = 1'b0;
                    end
                end
                dcc_pkg::OFF_IRQ_MASK:
                    st_next.irq_mask = PWDATA[0];
                default:
                begin
                end
            endcase
        end
        // set beats clear; a persisting mismatch keeps the flag up
        if (mismatch)
        begin
            st_next.irq_stat = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_reg         <= '0;
            {st_reg.b_inv, st_reg.a_inv, st_reg.in_sw} <= dcc_pkg::RST_CONFIG_RW[5:3];
            st_reg.mode    <= dcc_pkg::MODE_RESET;
            {st_reg.gss, st_reg.sync_en} <= dcc_pkg::RST_AUX;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PREADY       = 1'b1;
    assign PSLVERR      = access && !mapped;
    assign PRDATA       = st_reg.rdata;
    assign COMP_MODE    = st_reg.mode;
    // input switch only matters in the two multiplexed modes
    assign INPUT_SWITCH = st_reg.in_sw && ((st_reg.mode == dcc_pkg::MODE_MUX_A)
                        || (st_reg.mode == dcc_pkg::MODE_MUX_AB));
    assign COMP_A_OUT   = st_reg.out_q[0];
    assign COMP_B_OUT   = st_reg.out_q[1];
    assign IRQ          = st_reg.irq_stat && st_reg.irq_mask;

    assign gif.comp_b_out = st_reg.out_q[1];
    assign gif.gate_pin   = GATE_PIN;
    assign gif.gss        = st_reg.gss;
    assign gif.sync_en    = st_reg.sync_en;
    assign gif.tclk       = TIMER_CLK_SRC;
    assign TIMER_GATE     = gif.gate;

    dcc_gate u_gate
    (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .gif    (gif)
    );
endmodule

// File: testbench/dcc_props.sv
// Purpose: port assertions for dcc_top
// Assumes: one clock, zero wait apb
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module dcc_props
(
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [2:0]  COMP_MODE,
    input wire logic        COMP_ENABLE,
    input wire logic        INPUT_SWITCH,
    input wire logic        COMP_A_OUT,
    input wire logic        IRQ
);
    logic       cfg_wr;
    logic [2:0] wmode;
    assign cfg_wr = PSEL && PENABLE && PWRITE && PADDR == dcc_pkg::OFF_CONFIG;
    assign wmode  = PWDATA[2:0];
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence s_cfg_wr;
        cfg_wr;
    endsequence
    sequence s_irq_kept;
        IRQ && !(PSEL && PENABLE && PWRITE);
    endsequence
    a_mode_reset: assert property ($rose(ARST_N) |-> COMP_MODE == 3'h0)
        else $error("mode not reset");
    a_irq_reset: assert property ($rose(ARST_N) |-> !IRQ)
        else $error("irq high after reset");
    a_mode_write: assert property (s_cfg_wr |=> COMP_MODE == $past(wmode))
        else $error("mode write lost");
    a_mode_hold: assert property (!cfg_wr |=> $stable(COMP_MODE))
        else $error("mode moved without write");
    a_enable_mode: assert property (COMP_ENABLE == !(COMP_MODE inside {3'h0, 3'h7}))
        else $error("enable wrong for mode");
    a_out_off: assert property (!COMP_ENABLE |=> !COMP_A_OUT)
        else $error("output while disabled");
    a_switch_mode: assert property (!(COMP_MODE inside {3'h1, 3'h2}) |-> !INPUT_SWITCH)
        else $error("switch outside modes");
    a_irq_sticky: assert property (s_irq_kept |=> IRQ)
        else $error("irq dropped without write");
endmodule

// File: testbench/dcc_far_model.sv
// Purpose: companion timer with prescaled clock source
// Assumes: timer clock source is sys clock divided by 16
// Notes:   counts on rising source edge while gated
`timescale 1ns/1ps
module dcc_far_model
(
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire logic   gate,
    input  wire logic   timer_on,
    output logic        tclk,
    output logic [15:0] count
);
    logic [2:0] div_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_reg <= 3'h0;
            tclk <= 1'b0;
            count <= 16'h0000;
        end
        else
        begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == 3'h7)
            begin
                tclk <= !tclk;
                // software keeps the timer on and gated
                if (!tclk && timer_on && gate)
                    count <= count + 16'h0001;
            end
        end
    end
endmodule

// File: testbench/testbench.sv
// Purpose: self-checking bench for dcc_top
// Assumes: zero wait apb, lfsr stimulus
// Notes:   reads checked from an expectation queue
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] cfg_a = dcc_pkg::OFF_CONFIG;
    localparam logic [7:0] aux_a = dcc_pkg::OFF_AUX_CONFIG;
    localparam logic [7:0] sts_a = dcc_pkg::OFF_IRQ_STATUS;
    localparam logic [7:0] bad_a = 8'h20;
    logic        SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0]  PADDR, rnd;
    logic [31:0] PWDATA, PRDATA, exp_q[$];
    logic        COMP_A_RAW, COMP_B_RAW, TIMER_CLK_SRC, GATE_PIN, TIMER_GATE, g;
    logic        COMP_ENABLE, INPUT_SWITCH, COMP_A_OUT, COMP_B_OUT, IRQ;
    logic [2:0]  COMP_MODE;
    logic [15:0] tcount, t;
    int          bad_count, n_compared;
    dcc_top DUT (.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .COMP_A_RAW, .COMP_B_RAW, .TIMER_CLK_SRC, .GATE_PIN, .TIMER_GATE,
        .COMP_MODE, .COMP_ENABLE, .INPUT_SWITCH, .COMP_A_OUT, .COMP_B_OUT, .IRQ);
    dcc_far_model u_far (.clk(SYS_CLK), .arst_n(ARST_N), .gate(TIMER_GATE), .timer_on(1'b1),
        .tclk(TIMER_CLK_SRC), .count(tcount));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1)
            @(posedge SYS_CLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    // read data is judged at the access edge, where it stands
    always @(posedge SYS_CLK)
    begin
        if (PSEL && PENABLE && PREADY && !PWRITE && exp_q.size() > 0)
            chk(PRDATA, exp_q.pop_front());
        if (PSEL && PENABLE && PREADY)
            chk(32'(PSLVERR), 32'(PADDR == bad_a));
    end
    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        complete_run();
    end
    initial
    begin
        {ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {COMP_A_RAW, COMP_B_RAW, GATE_PIN, bad_count, n_compared} = '0;
        rnd = 8'h22;
        repeat (5) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        @(posedge SYS_CLK);
        rd(cfg_a, 32'h0);
        rd(aux_a, 32'(dcc_pkg::RST_AUX));
        rd(bad_a, 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, cfg_a, 32'(m) | 32'h8);
            chk(32'(INPUT_SWITCH), 32'(m == 1 || m == 2));
            chk(32'(COMP_ENABLE), 32'(m != 0 && m != 7));
            chk(32'(COMP_MODE), 32'(m));
        end
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            COMP_A_RAW <= rnd[0];
            COMP_B_RAW <= rnd[1];
            apb(1'b1, cfg_a, {24'h0, 2'h3, rnd[5:4], 4'h2});
            rd(cfg_a, {24'h0, rnd[1] ^ rnd[5], rnd[0] ^ rnd[4], rnd[5:4], 4'h2});
            chk(32'(COMP_A_OUT), 32'(rnd[0] ^ rnd[4]));
            chk(32'(COMP_B_OUT), 32'(rnd[1] ^ rnd[5]));
        end
        // irq: mismatch keeps the flag until the config is touched
        {COMP_A_RAW, COMP_B_RAW} <= 2'b00;
        apb(1'b1, dcc_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'b1, cfg_a, 32'h2);
        rd(cfg_a, 32'h2);
        apb(1'b1, sts_a, 32'h1);
        rd(sts_a, 32'h0);
        COMP_A_RAW <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        chk(32'(IRQ), 32'h1);
        // a cleared mask must hide the pending flag
        apb(1'b1, dcc_pkg::OFF_IRQ_MASK, 32'h0);
        chk(32'(IRQ), 32'h0);
        apb(1'b1, dcc_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'b1, sts_a, 32'h1);
        rd(sts_a, 32'h1);
        rd(cfg_a, 32'h42);
        apb(1'b1, sts_a, 32'h1);
        rd(sts_a, 32'h0);
        chk(32'(IRQ), 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            apb(1'b1, aux_a, {30'h0, rnd[2], 1'b0});
            COMP_B_RAW <= rnd[0];
            GATE_PIN <= rnd[1];
            repeat (3) @(posedge SYS_CLK);
            chk(32'(TIMER_GATE), 32'(rnd[2] ? rnd[1] : rnd[0]));
        end
        apb(1'b1, aux_a, 32'h1);
        @(negedge TIMER_CLK_SRC);
        @(posedge TIMER_CLK_SRC);
        g = COMP_B_RAW;
        COMP_B_RAW <= !g;
        repeat (3) @(posedge SYS_CLK);
        chk(32'(TIMER_GATE), 32'(g));
        @(negedge TIMER_CLK_SRC);
        repeat (3) @(posedge SYS_CLK);
        chk(32'(TIMER_GATE), 32'(!g));
        // software keeps sync on while comparator b gates the timer
        apb(1'b1, aux_a, 32'h1);
        COMP_B_RAW <= 1'b0;
        repeat (20) @(posedge SYS_CLK);
        t = tcount;
        repeat (40) @(posedge SYS_CLK);
        chk(32'(tcount), 32'(t));
        COMP_B_RAW <= 1'b1;
        repeat (40) @(posedge SYS_CLK);
        chk(32'(tcount != t), 32'h1);
        // mid-run reset must restore both registers
        ARST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        @(posedge SYS_CLK);
        rd(cfg_a, 32'h0);
        rd(aux_a, 32'(dcc_pkg::RST_AUX));
        chk(32'(IRQ), 32'h0);
        complete_run();
    end
endmodule
bind dcc_top dcc_props u_props (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .COMP_MODE(COMP_MODE),
    .COMP_ENABLE(COMP_ENABLE), .INPUT_SWITCH(INPUT_SWITCH), .COMP_A_OUT(COMP_A_OUT), .IRQ(IRQ));
